// >>> ocd_pkg.sv
// Contract
// - aes mode code selects exactly one mode
// - top info bit selects aes decrypt key
// - ccm/gcm key class from class2 key select
// - class2 aes mac only with confidentiality class1
// - class2 aes with class1 ccm/gcm errors
// - des modes exclusive, 80h adds parity check
// - hash codes plain, hmac, secret_prefix_mac, precomputed pads
// - crc base codes plus option bits
// - kasumi f8, f9 and gsm codes
// - snow codes f8 and f9
// - zuc codes cipher and auth engines
// - rng commands checked against handle instantiation
// - instantiate records prediction and test mode
// - generate with prediction reseeds or errors
// - reseed/uninstantiate ignore prediction bit
// - test bit must match handle mode
// - handle zero test mode allows nontest request
// - instantiate test bit selects deterministic mode
// - operation type decode into four classes
// - protocol waits for pending fifo stores
// - protocol start clears output data fifo
// - only handles zero and one exist
// - algorithm low 24 bits go to mode
// - protocol id and info fields extracted
package ocd_pkg;
  localparam logic [4:0] CMD_OPERATION = 5'h10;
  localparam int CT_HI = 31;
  localparam int CT_LO = 27;
  localparam int OT_HI = 26;
  localparam int OT_LO = 24;
  localparam int ALG_HI = 23;
  localparam int ALG_LO = 16;
  localparam int INFO_HI = 12;
  localparam int INFO_LO = 4;
  localparam int C2K_BIT = 13;
  localparam int AS_HI = 3;
  localparam int AS_LO = 2;
  localparam int PR_BIT = 1;
  localparam int TST_BIT = 0;
  localparam int SH_HI = 5;
  localparam int SH_LO = 4;
  localparam int MODE_HI = 23;
  localparam int PINFO_HI = 15;
  localparam logic [2:0] OT_UNI = 3'h0;
  localparam logic [2:0] OT_ACC = 3'h1;
  localparam logic [2:0] OT_C1 = 3'h2;
  localparam logic [2:0] OT_C2 = 3'h4;
  localparam logic [2:0] OT_DEC = 3'h6;
  localparam logic [2:0] OT_ENC = 3'h7;
  localparam logic [7:0] ALG_AES = 8'h10;
  localparam logic [7:0] ALG_DES = 8'h20;
  localparam logic [7:0] ALG_3DES = 8'h21;
  localparam logic [7:0] ALG_MD5 = 8'h40;
  localparam logic [7:0] ALG_SHA_LAST = 8'h47;
  localparam logic [7:0] ALG_RNG = 8'h50;
  localparam logic [7:0] ALG_SNOW8 = 8'h60;
  localparam logic [7:0] ALG_KAS = 8'h70;
  localparam logic [7:0] ALG_CRC = 8'h90;
  localparam logic [7:0] ALG_SNOW9 = 8'hA0;
  localparam logic [7:0] ALG_ZUC_CIPHER_ENGINE = 8'hB0;
  localparam logic [7:0] ALG_ZUC_AUTH_ENGINE = 8'hC0;
  localparam logic [7:0] AES_CMAC = 8'h60;
  localparam logic [7:0] AES_XCBC = 8'h70;
  localparam logic [7:0] AES_CCM = 8'h80;
  localparam logic [7:0] AES_GCM = 8'h90;
  localparam logic [7:0] AES_LAST = 8'hE0;
  localparam logic [7:0] DES_CBC = 8'h10;
  localparam logic [7:0] DES_OFB = 8'h40;
  localparam logic [7:0] DES_PARITY = 8'h80;
  localparam logic [7:0] HASH_HMAC = 8'h01;
  localparam logic [7:0] HASH_SECRET_PREFIX_MAC = 8'h02;
  localparam logic [7:0] HASH_PRE = 8'h04;
  localparam logic [7:0] CRC_802 = 8'h01;
  localparam logic [7:0] CRC_3385 = 8'h02;
  localparam logic [7:0] CRC_CUST = 8'h04;
  localparam logic [7:0] CRC_IVZ = 8'h80;
  localparam logic [7:0] CODE_F8 = 8'hC0;
  localparam logic [7:0] CODE_F9 = 8'hC8;
  localparam logic [7:0] KAS_GSM = 8'h10;
  localparam logic [1:0] AS_GEN = 2'h0;
  localparam logic [1:0] AS_INST = 2'h1;
  localparam logic [1:0] AS_RESEED = 2'h2;
  localparam logic [1:0] AS_UNINST = 2'h3;
  localparam int NUM_HANDLES = 2;
  localparam logic [1:0] HANDLE_LAST = 2'h1;
  typedef enum logic [2:0] {
    OCD_K_NONE, OCD_K_PROTO, OCD_K_C1, OCD_K_C2, OCD_K_ACC, OCD_K_BAD
  } ocd_kind_t;
endpackage

// >>> ocd_rng_check.sv
module ocd_rng_check (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic [1:0] i_cmd,
  input wire logic [1:0] i_handle,
  input wire logic i_pr,
  input wire logic i_tst,
  output logic o_done,
  output logic o_err,
  output logic o_test_err,
  output logic o_reseed_first,
  output logic [1:0] o_inst,
  output logic [1:0] o_det
);
  typedef struct packed {
    logic [1:0] inst;
    logic [1:0] pr_ok;
    logic [1:0] det;
    logic done;
    logic err;
    logic terr;
    logic rsf;
  } ocd_rng_st_t;
  ocd_rng_st_t s_q, s_d;
  logic h;
  logic bad_h, known, match;
  always_comb begin
    s_d = s_q;
    h = i_handle[0];
    bad_h = i_handle > ocd_pkg::HANDLE_LAST;
    known = s_q.inst[h];
    // handle zero test mode lets a nontest request through
    match = (s_q.det[h] == i_tst)
      || (!h && s_q.det[h] && !i_tst);
    s_d.done = 1'b0;
    s_d.err = 1'b0;
    s_d.terr = 1'b0;
    s_d.rsf = 1'b0;
    if (i_go) begin
      s_d.done = 1'b1;
      if (bad_h) begin
        s_d.err = 1'b1;
      end else if (i_cmd == ocd_pkg::AS_INST) begin
        if (known) begin
          s_d.err = 1'b1;
        end else begin
          s_d.inst[h] = 1'b1;
          s_d.pr_ok[h] = i_pr;
          s_d.det[h] = i_tst;
        end
      end else if (!known) begin
        s_d.err = 1'b1;
      end else if (!match) begin
        s_d.terr = 1'b1;
      end else if (i_cmd == ocd_pkg::AS_GEN) begin
        if (i_pr && !s_q.pr_ok[h]) begin
          s_d.err = 1'b1;
        end else begin
          s_d.rsf = i_pr;
        end
      end else if (i_cmd == ocd_pkg::AS_UNINST) begin
        s_d.inst[h] = 1'b0; // prediction bit ignored
        s_d.pr_ok[h] = 1'b0;
        s_d.det[h] = 1'b0;
      end
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign o_done = s_q.done;
  assign o_err = s_q.err;
  assign o_test_err = s_q.terr;
  assign o_reseed_first = s_q.rsf;
  assign o_inst = s_q.inst;
  assign o_det = s_q.det;

  property p_inst_twice;
    @(posedge i_mclk) disable iff (i_rst)
      i_go && i_cmd == ocd_pkg::AS_INST && i_handle < 2'h2
      && s_q.inst[i_handle[0]] |=> o_err;
  endproperty
  a_inst_twice: assert property (p_inst_twice)
    else $error("instantiate on live handle not refused");
  property p_gen_dead;
    @(posedge i_mclk) disable iff (i_rst)
      i_go && i_cmd != ocd_pkg::AS_INST && i_handle < 2'h2
      && !s_q.inst[i_handle[0]] |=> o_err && !o_test_err;
  endproperty
  a_gen_dead: assert property (p_gen_dead)
    else $error("command on dead handle not refused");
  property p_bad_handle;
    @(posedge i_mclk) disable iff (i_rst)
      i_go && i_handle[1] |=> o_err && $stable(o_inst);
  endproperty
  a_bad_handle: assert property (p_bad_handle)
    else $error("missing handle not refused");
  property p_inst_rec;
    @(posedge i_mclk) disable iff (i_rst)
      i_go && i_cmd == ocd_pkg::AS_INST && !i_handle[1]
      && !s_q.inst[i_handle[0]]
      |=> o_inst[$past(i_handle[0])]
      && o_det[$past(i_handle[0])] == $past(i_tst);
  endproperty
  a_inst_rec: assert property (p_inst_rec)
    else $error("instantiate mode not recorded");
  property p_test_mismatch;
    @(posedge i_mclk) disable iff (i_rst)
      i_go && i_cmd != ocd_pkg::AS_INST && i_handle == 2'h1
      && s_q.inst[1] && s_q.det[1] != i_tst |=> o_test_err;
  endproperty
  a_test_mismatch: assert property (p_test_mismatch)
    else $error("test mismatch not flagged");
  property p_h0_exempt;
    @(posedge i_mclk) disable iff (i_rst)
      i_go && i_cmd != ocd_pkg::AS_INST && i_handle == 2'h0
      && s_q.inst[0] && s_q.det[0] && !i_tst |=> !o_test_err;
  endproperty
  a_h0_exempt: assert property (p_h0_exempt)
    else $error("handle zero exemption broken");
  property p_pr_gen;
    @(posedge i_mclk) disable iff (i_rst)
      i_go && i_cmd == ocd_pkg::AS_GEN && i_pr && !i_handle[1]
      && s_q.inst[i_handle[0]] && match
      |=> (o_err != o_reseed_first);
  endproperty
  a_pr_gen: assert property (p_pr_gen)
    else $error("prediction generate wrong");
endmodule

// >>> ocd_decoder.sv
module ocd_decoder (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input wire logic [31:0] i_cmd_word,
  input wire logic i_store_pending,
  input wire logic i_c1_active_aes,
  input wire logic [7:0] i_c1_active_code,
  output logic o_cmd_ready,
  output logic o_done,
  output logic o_error,
  output logic o_test_error,
  output logic [2:0] o_kind,
  output logic [7:0] o_accel_alg,
  output logic [23:0] o_mode_word,
  output logic o_mode_load,
  output logic o_aes_decrypt_key_select,
  output logic o_aes_use_class2_key,
  output logic o_des_parity_check,
  output logic o_crc_zero_initial_value,
  output logic o_kas_gsm,
  output logic o_auth_engine,
  output logic [7:0] o_protocol_identifier,
  output logic [15:0] o_protocol_info_field,
  output logic o_out_fifo_clear,
  output logic o_rng_reseed_first,
  output logic [1:0] o_handle_instantiated
);
  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic is_hash(input logic [7:0] alg);
    is_hash = alg >= ocd_pkg::ALG_MD5 && alg <= ocd_pkg::ALG_SHA_LAST;
  endfunction
  function automatic logic f8f9_ok(input logic [7:0] code);
    f8f9_ok = code == ocd_pkg::CODE_F8 || code == ocd_pkg::CODE_F9;
  endfunction
  function automatic logic aes_ccm_gcm(input logic [7:0] code);
    aes_ccm_gcm = code == ocd_pkg::AES_CCM || code == ocd_pkg::AES_GCM;
  endfunction

  typedef enum logic [1:0] {
    ST_IDLE, ST_WAIT_STORE, ST_RNG, ST_RNG_WAIT
  } ocd_st_t;
  typedef struct packed {
    ocd_st_t st;
    logic ready;
    logic done;
    logic err;
    logic [2:0] kind;
    logic [7:0] alg;
    logic [23:0] mode;
    logic load;
    logic dk;
    logic c2k;
    logic par;
    logic crc_zero_initial_value;
    logic gsm;
    logic auth;
    logic [7:0] pid;
    logic [15:0] pinfo;
    logic fclr;
    logic [31:0] hold;
  } ocd_dec_st_t;
  ocd_dec_st_t s_q, s_d;

  logic [4:0] command_type_field;
  logic [2:0] otype;
  logic [7:0] alg, code;
  logic dk_bit, c2k;
  logic code_ok;
  logic rng_go, rng_done, rng_err, rng_terr, rng_rsf;
  logic [1:0] rng_inst;
  logic [31:0] w;

  ocd_rng_check u_rng (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_go(rng_go),
    .i_cmd(s_q.hold[ocd_pkg::AS_HI:ocd_pkg::AS_LO]),
    .i_handle(s_q.hold[ocd_pkg::SH_HI:ocd_pkg::SH_LO]),
    .i_pr(s_q.hold[ocd_pkg::PR_BIT]),
    .i_tst(s_q.hold[ocd_pkg::TST_BIT]),
    .o_done(rng_done),
    .o_err(rng_err),
    .o_test_err(rng_terr),
    .o_reseed_first(rng_rsf),
    .o_inst(rng_inst),
    .o_det()
  );

  // ****************************************
  // algorithm code check
  // ****************************************
  always_comb begin
    w = i_cmd_word;
    command_type_field = w[ocd_pkg::CT_HI:ocd_pkg::CT_LO];
    otype = w[ocd_pkg::OT_HI:ocd_pkg::OT_LO];
    alg = w[ocd_pkg::ALG_HI:ocd_pkg::ALG_LO];
    dk_bit = w[ocd_pkg::INFO_HI];
    code = w[ocd_pkg::INFO_HI-1:ocd_pkg::INFO_LO];
    c2k = w[ocd_pkg::C2K_BIT];
    code_ok = 1'b0;
    case (alg)
      ocd_pkg::ALG_AES: begin
        // one low-nibble-zero code only
        code_ok = code[3:0] == 4'h0 && code <= ocd_pkg::AES_LAST;
        if (otype == ocd_pkg::OT_C2) begin
          code_ok = code == ocd_pkg::AES_CMAC
            || code == ocd_pkg::AES_XCBC;
          if (i_c1_active_aes && (aes_ccm_gcm(i_c1_active_code)
              || i_c1_active_code >= ocd_pkg::AES_CMAC)) begin
            code_ok = 1'b0;
          end
        end
        if (c2k && !aes_ccm_gcm(code)) begin
          code_ok = 1'b0;
        end
      end
      ocd_pkg::ALG_DES, ocd_pkg::ALG_3DES: begin
        code_ok = !dk_bit && code[3:0] == 4'h0
          && code[6:0] >= ocd_pkg::DES_CBC
          && code[6:0] <= ocd_pkg::DES_OFB;
      end
      ocd_pkg::ALG_CRC: begin
        code_ok = !dk_bit && (code[3:0] == ocd_pkg::CRC_802[3:0]
          || code[3:0] == ocd_pkg::CRC_3385[3:0]
          || code[3:0] == ocd_pkg::CRC_CUST[3:0]);
      end
      ocd_pkg::ALG_KAS: begin
        code_ok = !dk_bit && (f8f9_ok(code)
          || f8f9_ok(code & ~ocd_pkg::KAS_GSM));
      end
      ocd_pkg::ALG_SNOW8, ocd_pkg::ALG_SNOW9: begin
        code_ok = !dk_bit && f8f9_ok(code);
      end
      ocd_pkg::ALG_ZUC_CIPHER_ENGINE, ocd_pkg::ALG_ZUC_AUTH_ENGINE: begin
        code_ok = !dk_bit && f8f9_ok(code);
      end
      ocd_pkg::ALG_RNG: begin
        code_ok = 1'b1;
      end
      default: begin
        code_ok = !dk_bit && is_hash(alg)
          && (code == 8'h00 || code == ocd_pkg::HASH_HMAC
          || code == ocd_pkg::HASH_SECRET_PREFIX_MAC || code == ocd_pkg::HASH_PRE);
      end
    endcase
  end

  // ****************************************
  // command sequencing
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.load = 1'b0;
    s_d.fclr = 1'b0;
    rng_go = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        s_d.ready = 1'b1;
        if (i_cmd_valid && s_q.ready) begin
          s_d.hold = w;
          s_d.err = 1'b0;
          s_d.alg = alg;
          if (command_type_field != ocd_pkg::CMD_OPERATION) begin
            s_d.kind = ocd_pkg::OCD_K_BAD;
            s_d.err = 1'b1;
            s_d.done = 1'b1;
          end else begin
            case (otype)
              ocd_pkg::OT_UNI, ocd_pkg::OT_DEC, ocd_pkg::OT_ENC: begin
                s_d.kind = ocd_pkg::OCD_K_PROTO;
                s_d.ready = 1'b0;
                s_d.st = ST_WAIT_STORE;
              end
              ocd_pkg::OT_C1, ocd_pkg::OT_C2: begin
                s_d.kind = otype == ocd_pkg::OT_C1 ? ocd_pkg::OCD_K_C1
                  : ocd_pkg::OCD_K_C2;
                if (alg == ocd_pkg::ALG_RNG
                    && otype == ocd_pkg::OT_C1) begin
                  s_d.ready = 1'b0;
                  s_d.st = ST_RNG;
                end else begin
                  s_d.done = 1'b1;
                  s_d.err = !code_ok;
                  s_d.load = code_ok;
                  s_d.mode = w[ocd_pkg::MODE_HI:0];
                  s_d.dk = alg == ocd_pkg::ALG_AES && dk_bit;
                  s_d.c2k = alg == ocd_pkg::ALG_AES && c2k;
                  s_d.par = code[7];
                  s_d.crc_zero_initial_value = code[7];
                  s_d.gsm = code[4];
                  s_d.auth = code[3];
                end
              end
              ocd_pkg::OT_ACC: begin
                s_d.kind = ocd_pkg::OCD_K_ACC;
                s_d.done = 1'b1;
                s_d.load = 1'b1;
                s_d.mode = w[ocd_pkg::MODE_HI:0];
              end
              default: begin
                s_d.kind = ocd_pkg::OCD_K_BAD;
                s_d.err = 1'b1;
                s_d.done = 1'b1;
              end
            endcase
          end
        end
      end
      ST_WAIT_STORE: begin
        if (!i_store_pending) begin
          s_d.fclr = 1'b1;
          s_d.pid = s_q.hold[ocd_pkg::ALG_HI:ocd_pkg::ALG_LO];
          s_d.pinfo = s_q.hold[ocd_pkg::PINFO_HI:0];
          s_d.done = 1'b1;
          s_d.ready = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      ST_RNG: begin
        rng_go = 1'b1;
        s_d.st = ST_RNG_WAIT;
      end
      ST_RNG_WAIT: begin
        if (rng_done) begin
          s_d.done = 1'b1;
          s_d.err = rng_err;
          s_d.ready = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  logic terr_q;
  logic rsf_q;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      terr_q <= 1'b0;
      rsf_q <= 1'b0;
    end else begin
      terr_q <= rng_done && rng_terr;
      rsf_q <= rng_done && rng_rsf;
    end
  end

  assign o_cmd_ready = s_q.ready;
  assign o_done = s_q.done;
  assign o_error = s_q.err;
  assign o_test_error = terr_q;
  assign o_kind = s_q.kind;
  assign o_accel_alg = s_q.alg;
  assign o_mode_word = s_q.mode;
  assign o_mode_load = s_q.load;
  assign o_aes_decrypt_key_select = s_q.dk;
  assign o_aes_use_class2_key = s_q.c2k;
  assign o_des_parity_check = s_q.par;
  assign o_crc_zero_initial_value = s_q.crc_zero_initial_value;
  assign o_kas_gsm = s_q.gsm;
  assign o_auth_engine = s_q.auth;
  assign o_protocol_identifier = s_q.pid;
  assign o_protocol_info_field = s_q.pinfo;
  assign o_out_fifo_clear = s_q.fclr;
  assign o_rng_reseed_first = rsf_q;
  assign o_handle_instantiated = rng_inst;

  // ****************************************
  // checks
  // ****************************************
  sequence s_proto_taken;
    i_cmd_valid && o_cmd_ready && i_cmd_word[31:27] == 5'h10
    && (i_cmd_word[26:24] == 3'h0 || i_cmd_word[26:25] == 2'h3);
  endsequence
  property p_clear_waits;
    @(posedge i_mclk) disable iff (i_rst)
      o_out_fifo_clear |-> !$past(i_store_pending);
  endproperty
  a_clear_waits: assert property (p_clear_waits)
    else $error("fifo cleared while store pending");
  property p_proto_clear;
    @(posedge i_mclk) disable iff (i_rst)
      s_proto_taken ##1 !i_store_pending |=> o_out_fifo_clear && o_done;
  endproperty
  a_proto_clear: assert property (p_proto_clear)
    else $error("protocol start did not clear fifo");
  property p_proto_fields;
    @(posedge i_mclk) disable iff (i_rst)
      s_proto_taken ##1 !i_store_pending
      |=> o_protocol_identifier == $past(i_cmd_word[23:16], 2);
  endproperty
  a_proto_fields: assert property (p_proto_fields)
    else $error("protocol id not extracted");
  property p_mode_copy;
    @(posedge i_mclk) disable iff (i_rst)
      o_mode_load && o_kind == 3'(ocd_pkg::OCD_K_C1)
      |-> o_mode_word == $past(i_cmd_word[23:0]);
  endproperty
  a_mode_copy: assert property (p_mode_copy)
    else $error("mode word not copied");
  property p_reserved_type;
    @(posedge i_mclk) disable iff (i_rst)
      i_cmd_valid && o_cmd_ready && i_cmd_word[26:24] == 3'h3
      |=> o_error && o_done && !o_mode_load;
  endproperty
  a_reserved_type: assert property (p_reserved_type)
    else $error("reserved type not flagged");
  property p_aes_dk;
    @(posedge i_mclk) disable iff (i_rst)
      i_cmd_valid && o_cmd_ready && i_cmd_word[31:16] == 16'h8210
      |=> o_aes_decrypt_key_select == $past(i_cmd_word[12]);
  endproperty
  a_aes_dk: assert property (p_aes_dk)
    else $error("decrypt key select wrong");
  property p_aes_excl;
    @(posedge i_mclk) disable iff (i_rst)
      i_cmd_valid && o_cmd_ready && i_cmd_word[31:16] == 16'h8210
      && i_cmd_word[7:4] != 4'h0 |=> o_error;
  endproperty
  a_aes_excl: assert property (p_aes_excl)
    else $error("combined aes code accepted");
  property p_des_range;
    @(posedge i_mclk) disable iff (i_rst)
      i_cmd_valid && o_cmd_ready && i_cmd_word[31:16] == 16'h8220
      && i_cmd_word[12:4] == 9'h050 |=> o_error;
  endproperty
  a_des_range: assert property (p_des_range)
    else $error("bad des code accepted");
endmodule

// >>> ocd_far_model.sv
// ****************
// far side: fifo stores and class1 status
// ****************
module ocd_far_model (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_stall,
  input wire logic [3:0] i_len,
  input wire logic i_aes,
  input wire logic [7:0] i_code,
  output logic o_store_pending,
  output logic o_c1_active_aes,
  output logic [7:0] o_c1_active_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  // outstanding stores drain before protocol
  always_ff @(posedge i_mclk) begin
    if (i_rst) cnt_q <= 4'h0;
    else if (i_stall) cnt_q <= i_len;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  end
  assign o_store_pending = cnt_q != 4'h0;
  assign o_c1_active_aes = i_aes;
  // code not held when idle
  assign o_c1_active_code = i_aes ? i_code : ~i_code;
endmodule

// >>> operation_command_decoder_test.sv
module operation_command_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [4:0] ek;
    logic [4:0] ekm;
    logic [33:0] msk;
    logic [33:0] val;
    int tmin;
    int t0;
    logic ld;
  } ocd_note_t;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic valid = 1'b0;
  logic [31:0] word = 32'h0;
  logic stall = 1'b0;
  logic [3:0] len = 4'h0;
  logic aes = 1'b0;
  logic [7:0] code = 8'h0;
  logic pend, c1a, rdy, done, err, terr, dk, c2k, par, crc_zero_initial_value, gsm, auth;
  logic clr, rsf, ld;
  logic [7:0] c1c, pid, alg;
  logic [2:0] kind;
  logic [23:0] mode;
  logic [15:0] pinfo;
  logic [1:0] inst;
  logic [33:0] obs;
  logic [31:0] r;
  ocd_note_t notes[$];
  ocd_note_t mn;
  int cyc = 0;
  int checks = 0;
  int err_total = 0;

  ocd_far_model far (.i_mclk(i_mclk), .i_rst(i_rst), .i_stall(stall),
    .i_len(len), .i_aes(aes), .i_code(code), .o_store_pending(pend),
    .o_c1_active_aes(c1a), .o_c1_active_code(c1c));
  ocd_decoder DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_cmd_valid(valid),
    .i_cmd_word(word), .i_store_pending(pend), .i_c1_active_aes(c1a),
    .i_c1_active_code(c1c), .o_cmd_ready(rdy), .o_done(done),
    .o_error(err), .o_test_error(terr), .o_kind(kind), .o_accel_alg(alg),
    .o_mode_word(mode), .o_mode_load(ld), .o_aes_decrypt_key_select(dk),
    .o_aes_use_class2_key(c2k), .o_des_parity_check(par),
    .o_crc_zero_initial_value(crc_zero_initial_value), .o_kas_gsm(gsm), .o_auth_engine(auth),
    .o_protocol_identifier(pid), .o_protocol_info_field(pinfo),
    .o_out_fifo_clear(clr), .o_rng_reseed_first(rsf),
    .o_handle_instantiated(inst));
  assign obs = {clr, rsf, inst, dk, c2k, par, crc_zero_initial_value, gsm, auth,
    kind == 3'h1 ? {pid, pinfo} : mode};

  // ****************
  // clock, tasks
  // ****************
  initial begin
    forever #50 i_mclk = ~i_mclk;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [31:0] w, input logic [4:0] ek,
      input logic [4:0] ekm, input logic [33:0] m, input logic [33:0] v,
      input logic [3:0] sl);
    ocd_note_t n;
    @(posedge i_mclk);
    valid <= 1'b1;
    word <= w;
    stall <= sl != 4'h0;
    len <= sl;
    do @(posedge i_mclk); while (rdy !== 1'b1);
    n.ek = ek;
    n.ekm = ekm;
    n.msk = m;
    n.val = v;
    n.tmin = ek[2:0] == 3'h1 ? sl + 2 : 1;
    n.ld = !ek[4] && ek[2:0] inside {3'h2, 3'h3, 3'h4}
      && !(ek[2:0] == 3'h2 && w[23:16] == 8'h50);
    n.t0 = cyc;
    notes.push_back(n);
    valid <= 1'b0;
    stall <= 1'b0;
  endtask
  task automatic go(input logic [2:0] ot, input logic [7:0] a,
      input logic [15:0] lo, input logic e, input logic [33:0] m,
      input logic [33:0] v, input logic [3:0] sl);
    logic [2:0] k;
    k = ot == 3'h2 ? 3'h2 : ot == 3'h4 ? 3'h3 : ot == 3'h1 ? 3'h4 :
      (ot == 3'h3 || ot == 3'h5) ? 3'h5 : 3'h1;
    cmd({5'h10, ot, a, lo}, {e, 1'b0, k},
      (e && k != 3'h5) ? 5'h18 : 5'h1F,
      e ? 34'h0 : m | {1'b1, 9'h0, k == 3'h4 ? 24'h0 : 24'hFFFFFF},
      v | {k == 3'h1, 9'h0, a, lo}, sl);
  endtask
  task automatic rng(input logic [1:0] h, input logic [1:0] as,
      input logic pr, input logic t, input logic e, input logic te,
      input logic rf, input logic im, input logic [1:0] iv);
    cmd({5'h10, 3'h2, 8'h50, 10'h0, h, as, pr, t}, {e, te, 3'h2}, 5'h18,
      {1'b0, ~e, {2{im}}, 30'h0}, {1'b0, rf, iv, 6'h0, 8'h50, 16'h0}, 4'h0);
  endtask

  // ****************
  // monitor, timeout
  // ****************
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end else if (done === 1'b1) begin
      if (notes.size() == 0) check(34'h1, 34'h0);
      else begin
        mn = notes.pop_front();
        check({29'h0, {err, terr, kind} & mn.ekm}, {29'h0, mn.ek & mn.ekm});
        check(obs & mn.msk, mn.val & mn.msk);
        check({33'h0, cyc - mn.t0 >= mn.tmin}, 34'h1);
        check(34'(alg), 34'(mn.val[23:16]));
        check(34'(ld), 34'(mn.ld));
      end
    end
  end

  // ****************
  // scenarios
  // ****************
  initial begin
    void'($urandom(32'h6c9eae0a));
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    for (int i = 0; i < 15; i++) begin
      r = $urandom;
      go(3'h2, 8'h10, {3'h0, r[0], i[3:0], 8'h0}, 1'b0, 34'h1 << 29,
        34'(r[0]) << 29, 4'h0);
    end
    go(3'h2, 8'h10, 16'h0F00, 1'b1, 34'h0, 34'h0, 4'h0);
    go(3'h2, 8'h10, 16'h0130, 1'b1, 34'h0, 34'h0, 4'h0);
    go(3'h2, 8'h10, 16'h2800, 1'b0, 34'h1 << 28, 34'h1 << 28, 4'h0);
    go(3'h2, 8'h10, 16'h0900, 1'b0, 34'h1 << 28, 34'h0, 4'h0);
    go(3'h2, 8'h10, 16'h2000, 1'b1, 34'h0, 34'h0, 4'h0);
    for (int j = 0; j < 4; j++) begin
      @(posedge i_mclk);
      aes <= 1'b1;
      code <= j[0] ? 8'h80 : 8'h20;
      go(3'h4, 8'h10, j[1] ? 16'h0700 : 16'h0600, j[0], 34'h0, 34'h0,
        4'h0);
    end
    aes <= 1'b0;
    for (int i = 1; i < 5; i++) begin
      r = $urandom;
      go(3'h2, 8'h20, {4'h0, r[0], i[2:0], 8'h0}, 1'b0, 34'h1 << 27,
        34'(r[0]) << 27, 4'h0);
    end
    go(3'h2, 8'h20, 16'h0500, 1'b1, 34'h0, 34'h0, 4'h0);
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      go(3'h4, 8'h40 + 8'(r[2:0]), {4'h0, i == 3 ? 8'h04 : 8'(i), 4'h0},
        1'b0, 34'h0, 34'h0, 4'h0);
    end
    go(3'h4, 8'h41, 16'h0030, 1'b1, 34'h0, 34'h0, 4'h0);
    for (int i = 0; i < 3; i++) begin
      r = $urandom;
      go(3'h4, 8'h90, {4'h0, r[3:0], 4'(1 << i), 4'h0}, 1'b0, 34'h1 << 26,
        34'(r[3]) << 26, 4'h0);
    end
    go(3'h2, 8'h70, 16'h0C00, 1'b0, 34'h1 << 25, 34'h0, 4'h0);
    go(3'h2, 8'h70, 16'h0D80, 1'b0, 34'h1 << 25, 34'h1 << 25, 4'h0);
    go(3'h2, 8'h70, 16'h0000, 1'b1, 34'h0, 34'h0, 4'h0);
    go(3'h2, 8'h60, 16'h0C00, 1'b0, 34'h0, 34'h0, 4'h0);
    go(3'h4, 8'hA0, 16'h0C80, 1'b0, 34'h0, 34'h0, 4'h0);
    go(3'h2, 8'hB0, 16'h0C00, 1'b0, 34'h1 << 24, 34'h0, 4'h0);
    go(3'h4, 8'hC0, 16'h0C80, 1'b0, 34'h1 << 24, 34'h1 << 24, 4'h0);
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      if (i != 2 && i != 4)
        go(3'(i), r[23:16], r[15:0], i == 3 || i == 5, 34'h0, 34'h0,
          i == 6 ? 4'h6 : 4'h0);
    end
    cmd(32'h41000000, 5'h15, 5'h1F, 34'h0, 34'h0, 4'h0);
    rng(2'h1, 2'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0);
    rng(2'h1, 2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    rng(2'h1, 2'h1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 2'h2);
    rng(2'h1, 2'h0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0);
    rng(2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0);
    rng(2'h0, 2'h1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    rng(2'h0, 2'h0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 2'h3);
    rng(2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    rng(2'h0, 2'h2, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    rng(2'h0, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    rng(2'h0, 2'h3, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    rng(2'h2, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 2'h2);
    rng(2'h0, 2'h2, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
    rng(2'h1, 2'h3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    rng(2'h1, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h2);
    rng(2'h1, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0);
    repeat (10) @(posedge i_mclk);
    check(34'(notes.size()), 34'h0);
    finish_test();
  end
endmodule
